// ==== gpm_defs.svh ====
// Offsets, reset values and field positions of the port and pin-mux block.
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH
`define GPM_AW 5
`define GPM_OFF_D_PULL 5'h00
`define GPM_OFF_D_DATA 5'h01
`define GPM_OFF_D_DIR 5'h02
`define GPM_OFF_D_PEREN 5'h03
`define GPM_OFF_D_IASSERT 5'h04
`define GPM_OFF_D_IEN 5'h05
`define GPM_OFF_D_IPOL 5'h06
`define GPM_OFF_D_IPEND 5'h07
`define GPM_OFF_D_IEDGE 5'h08
`define GPM_OFF_D_PPMODE 5'h09
`define GPM_OFF_D_RAW 5'h0a
`define GPM_OFF_D_DRIVE 5'h0b
`define GPM_OFF_PINSEL 5'h10
`define GPM_OFF_A_DATA 5'h11
`define GPM_OFF_A_DIR 5'h12
`define GPM_OFF_A_PEREN 5'h13
`define GPM_OFF_B_DATA 5'h14
`define GPM_OFF_B_DIR 5'h15
`define GPM_OFF_B_PEREN 5'h16
`define GPM_OFF_C_DATA 5'h17
`define GPM_OFF_C_DIR 5'h18
`define GPM_OFF_C_PEREN 5'h19
`define GPM_OFF_A_RAW 5'h1a
`define GPM_OFF_B_RAW 5'h1b
`define GPM_OFF_C_RAW 5'h1c
`define GPM_RST_D_ONES 4'hf
`define GPM_RST_D_ZERO 4'h0
`define GPM_RST_A_PEREN 8'h80
`define GPM_RST_B_PEREN 8'h00
`define GPM_RST_C_PEREN 8'hff
`define GPM_RST_ZERO8 8'h00
`define GPM_RST_PINSEL 8'h00
`define GPM_A_PINS_MASK 8'hff
`define GPM_B_PINSEL_BIT0 0
`define GPM_B_PINSEL_BIT1 1
`define GPM_B_PINSEL_BIT2 2
`define GPM_B_PINSEL_BIT3 3
`define GPM_B_PINSEL_BIT4 4
`define GPM_B_PINSEL_BIT5 5
`define GPM_B_PINSEL_BIT6 6
`define GPM_B_PINSEL_BIT7 7
`endif

// ==== gpm_pkg.sv ====
// Types shared by the port and pin-mux block.
package gpm_pkg;
  typedef logic [15:0] gpm_word_t;
  typedef logic [7:0] gpm_port8_t;
  typedef logic [3:0] gpm_port4_t;
endpackage

// ==== gpm_pin_if.sv ====
// Per-port bundle between the port logic and the pin-mux wiring.
`timescale 1ns/100ps
interface gpm_pin_if;
  logic [7:0] gp_out; // GPIO output data
  logic [7:0] gp_dir; // GPIO direction, 1 = output
  logic [7:0] per_en; // Peripheral owns the pin
  logic [7:0] raw_in; // Synchronised pin level
  modport port (output gp_out, output gp_dir, output per_en, input raw_in);
  modport pins (input gp_out, input gp_dir, input per_en, output raw_in);
endinterface

// ==== gpm_pin_sync.sv ====
// Two-flop synchroniser for a group of port pins.
`timescale 1ns/100ps
module gpm_pin_sync
  import gpm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_sync
);
  // ----------------------------------------
  // Sync stages
  // ----------------------------------------
  logic [7:0] meta_r; // First stage, read only by second
  // Pins are asynchronous to mclk
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_r <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      meta_r <= pin_in;
      pin_sync <= meta_r;
    end
  end
endmodule

// ==== gpm_top.sv ====
// Four GPIO ports with chip pin-select muxing and port D register file.
//
// Contract
// RULE1 - Four ports: A six, B/C eight, D four
// RULE2 - B0 GPIO default; pinsel picks SPI clock/SCL
// RULE3 - B1 GPIO default; pinsel picks SS/SDA
// RULE4 - B2,B3 pinsel picks SPI data or timer
// RULE5 - B4 pinsel picks timer0 or clock output
// RULE6 - B5 pinsel picks timer1 or pwm_fault_input_3
// RULE7 - B6 pinsel picks serial receive or SDA
// RULE8 - B6 external clock enabled by PLL control
// RULE9 - B7 pinsel picks serial transmit or SCL
// RULE10 - A3, A6 exist unbonded, default GPIO
// RULE11 - Reset: A GPIO but A7 reset, C analog, D JTAG
// RULE12 - Port D reset values per register map
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "gpm_defs.svh"
module gpm_top
  import gpm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output gpm_word_t reg_rdata,
  // Pins (output enable low while driving)
  input wire logic [7:0] pa_in,
  output gpm_port8_t pa_out,
  output gpm_port8_t pa_oe_n,
  input wire logic [7:0] pb_in,
  output gpm_port8_t pb_out,
  output gpm_port8_t pb_oe_n,
  input wire logic [7:0] pc_in,
  output gpm_port8_t pc_out,
  output gpm_port8_t pc_oe_n,
  output gpm_port8_t pc_analog_sel,
  input wire logic [3:0] pd_in,
  output gpm_port4_t pd_out,
  output gpm_port4_t pd_oe_n,
  output gpm_port4_t pd_pull_en,
  output gpm_port4_t pd_open_drain,
  output gpm_port4_t pd_high_drive,
  output gpm_port4_t pd_irq_pending,
  // Peripheral side of port B
  input wire logic spi_sclk_out,
  input wire logic spi_sclk_oe,
  input wire logic i2c_scl_out_n,
  input wire logic spi_ss_out,
  input wire logic spi_ss_oe,
  input wire logic i2c_sda_out_n,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe,
  input wire logic spi_mosi_out,
  input wire logic spi_mosi_oe,
  input wire logic timer_channel_0_out,
  input wire logic timer_channel_0_oe,
  input wire logic timer_channel_1_out,
  input wire logic timer_channel_1_oe,
  input wire logic timer_channel_2_out,
  input wire logic timer_channel_2_oe,
  input wire logic timer_channel_3_out,
  input wire logic timer_channel_3_oe,
  input wire logic internal_clock_output,
  input wire logic sci_txd_out,
  input wire logic pll_ext_clk_en,
  output gpm_port8_t pb_periph_in,
  output logic external_clock_input,
  output logic pwm_fault_input_3,
  // Peripheral side of ports A and D
  input wire logic [7:0] pa_periph_out,
  input wire logic [7:0] pa_periph_oe,
  output gpm_port8_t pa_periph_in,
  input wire logic [3:0] jtag_out,
  input wire logic [3:0] jtag_oe,
  output gpm_port4_t jtag_in
);
  // ----------------------------------------
  // Pin synchronisers and port bundles
  // ----------------------------------------
  gpm_pin_if a_if ();
  gpm_pin_if b_if ();
  gpm_pin_if c_if ();
  logic [7:0] d_sync; // Port D raw level, upper bits idle
  gpm_pin_sync u_sync_a (.mclk(mclk), .rst(rst), .pin_in(pa_in), .pin_sync(a_if.raw_in));
  gpm_pin_sync u_sync_b (.mclk(mclk), .rst(rst), .pin_in(pb_in), .pin_sync(b_if.raw_in));
  gpm_pin_sync u_sync_c (.mclk(mclk), .rst(rst), .pin_in(pc_in), .pin_sync(c_if.raw_in));
  gpm_pin_sync u_sync_d (.mclk(mclk), .rst(rst), .pin_in({4'h0, pd_in}), .pin_sync(d_sync));

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] pinsel_r; // Chip pin-select register, bit n for port B pin n
  logic [7:0] a_data_r, a_dir_r, a_peren_r;
  logic [7:0] b_data_r, b_dir_r, b_peren_r;
  logic [7:0] c_data_r, c_dir_r, c_peren_r;
  logic [3:0] d_pull_r, d_data_r, d_dir_r, d_peren_r; // Port D control
  logic [3:0] d_iassert_r, d_ien_r, d_ipol_r, d_iedge_r;
  logic [3:0] d_ppmode_r, d_drive_r;
  logic [3:0] d_prev_r; // Last sampled port D level for edge detect
  logic [3:0] d_edge_evt; // Active edge seen this cycle

  // Write decode helper, used by every register
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a == off;
  endfunction

  // Chip pin-select: only port B carries selectable roles here
  always_ff @(posedge mclk) begin
    if (rst) begin
      pinsel_r <= `GPM_RST_PINSEL;
    end else if (reg_wr && hit(reg_addr, `GPM_OFF_PINSEL)) begin
      pinsel_r <= reg_wdata[7:0];
    end
  end

  // Ports A, B and C control registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      a_data_r <= `GPM_RST_ZERO8;
      a_dir_r <= `GPM_RST_ZERO8;
      a_peren_r <= `GPM_RST_A_PEREN; // see RULE11 (A7 comes up as reset input)
      b_data_r <= `GPM_RST_ZERO8;
      b_dir_r <= `GPM_RST_ZERO8;
      b_peren_r <= `GPM_RST_B_PEREN; // see RULE2 see RULE3 see RULE9 (all B GPIO)
      c_data_r <= `GPM_RST_ZERO8;
      c_dir_r <= `GPM_RST_ZERO8;
      c_peren_r <= `GPM_RST_C_PEREN; // see RULE11 (C comes up analog)
    end else if (reg_wr) begin
      // A3 and A6 stay writable though unbonded, see RULE10
      if (hit(reg_addr, `GPM_OFF_A_DATA)) a_data_r <= reg_wdata[7:0];
      if (hit(reg_addr, `GPM_OFF_A_DIR)) a_dir_r <= reg_wdata[7:0];
      if (hit(reg_addr, `GPM_OFF_A_PEREN)) a_peren_r <= reg_wdata[7:0];
      if (hit(reg_addr, `GPM_OFF_B_DATA)) b_data_r <= reg_wdata[7:0];
      if (hit(reg_addr, `GPM_OFF_B_DIR)) b_dir_r <= reg_wdata[7:0];
      if (hit(reg_addr, `GPM_OFF_B_PEREN)) b_peren_r <= reg_wdata[7:0];
      if (hit(reg_addr, `GPM_OFF_C_DATA)) c_data_r <= reg_wdata[7:0];
      if (hit(reg_addr, `GPM_OFF_C_DIR)) c_dir_r <= reg_wdata[7:0];
      if (hit(reg_addr, `GPM_OFF_C_PEREN)) c_peren_r <= reg_wdata[7:0];
    end
  end

  // Port D control registers, reset per map
  always_ff @(posedge mclk) begin
    if (rst) begin
      d_pull_r <= `GPM_RST_D_ONES; // see RULE12
      d_data_r <= `GPM_RST_D_ZERO;
      d_dir_r <= `GPM_RST_D_ZERO;
      d_peren_r <= `GPM_RST_D_ONES; // see RULE11 see RULE12 (JTAG owns D)
      d_iassert_r <= `GPM_RST_D_ZERO;
      d_ien_r <= `GPM_RST_D_ZERO;
      d_ipol_r <= `GPM_RST_D_ZERO;
      d_ppmode_r <= `GPM_RST_D_ONES; // see RULE12
      d_drive_r <= `GPM_RST_D_ZERO;
    end else if (reg_wr) begin
      if (hit(reg_addr, `GPM_OFF_D_PULL)) d_pull_r <= reg_wdata[3:0];
      if (hit(reg_addr, `GPM_OFF_D_DATA)) d_data_r <= reg_wdata[3:0];
      if (hit(reg_addr, `GPM_OFF_D_DIR)) d_dir_r <= reg_wdata[3:0];
      if (hit(reg_addr, `GPM_OFF_D_PEREN)) d_peren_r <= reg_wdata[3:0];
      if (hit(reg_addr, `GPM_OFF_D_IASSERT)) d_iassert_r <= reg_wdata[3:0];
      if (hit(reg_addr, `GPM_OFF_D_IEN)) d_ien_r <= reg_wdata[3:0];
      if (hit(reg_addr, `GPM_OFF_D_IPOL)) d_ipol_r <= reg_wdata[3:0];
      if (hit(reg_addr, `GPM_OFF_D_PPMODE)) d_ppmode_r <= reg_wdata[3:0];
      if (hit(reg_addr, `GPM_OFF_D_DRIVE)) d_drive_r <= reg_wdata[3:0];
    end
  end

  // ----------------------------------------
  // Port D edge status
  // ----------------------------------------
  // Polarity 0 catches rising edges, 1 catches falling ones
  assign d_edge_evt = d_ien_r & ((d_sync[3:0] & ~d_prev_r & ~d_ipol_r)
                                 | (~d_sync[3:0] & d_prev_r & d_ipol_r));

  // Write one to clear; a new edge in the same cycle wins over the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      d_prev_r <= `GPM_RST_D_ZERO;
      d_iedge_r <= `GPM_RST_D_ZERO; // see RULE12
    end else begin
      d_prev_r <= d_sync[3:0];
      if (reg_wr && hit(reg_addr, `GPM_OFF_D_IEDGE)) begin
        d_iedge_r <= (d_iedge_r & ~reg_wdata[3:0]) | d_edge_evt;
      end else begin
        d_iedge_r <= d_iedge_r | d_edge_evt;
      end
    end
  end

  // Pending shows edges or software-asserted bits while enabled
  assign pd_irq_pending = (d_iedge_r | d_iassert_r) & d_ien_r;

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  gpm_word_t rd_nxt; // Read data for the next cycle
  always_comb begin
    rd_nxt = 16'h0000;
    case (reg_addr)
      `GPM_OFF_D_PULL: rd_nxt[3:0] = d_pull_r;
      `GPM_OFF_D_DATA: rd_nxt[3:0] = d_data_r;
      `GPM_OFF_D_DIR: rd_nxt[3:0] = d_dir_r;
      `GPM_OFF_D_PEREN: rd_nxt[3:0] = d_peren_r;
      `GPM_OFF_D_IASSERT: rd_nxt[3:0] = d_iassert_r;
      `GPM_OFF_D_IEN: rd_nxt[3:0] = d_ien_r;
      `GPM_OFF_D_IPOL: rd_nxt[3:0] = d_ipol_r;
      `GPM_OFF_D_IPEND: rd_nxt[3:0] = pd_irq_pending;
      `GPM_OFF_D_IEDGE: rd_nxt[3:0] = d_iedge_r;
      `GPM_OFF_D_PPMODE: rd_nxt[3:0] = d_ppmode_r;
      `GPM_OFF_D_RAW: rd_nxt[3:0] = d_sync[3:0];
      `GPM_OFF_D_DRIVE: rd_nxt[3:0] = d_drive_r;
      `GPM_OFF_PINSEL: rd_nxt[7:0] = pinsel_r;
      `GPM_OFF_A_DATA: rd_nxt[7:0] = a_data_r;
      `GPM_OFF_A_DIR: rd_nxt[7:0] = a_dir_r;
      `GPM_OFF_A_PEREN: rd_nxt[7:0] = a_peren_r;
      `GPM_OFF_B_DATA: rd_nxt[7:0] = b_data_r;
      `GPM_OFF_B_DIR: rd_nxt[7:0] = b_dir_r;
      `GPM_OFF_B_PEREN: rd_nxt[7:0] = b_peren_r;
      `GPM_OFF_C_DATA: rd_nxt[7:0] = c_data_r;
      `GPM_OFF_C_DIR: rd_nxt[7:0] = c_dir_r;
      `GPM_OFF_C_PEREN: rd_nxt[7:0] = c_peren_r;
      `GPM_OFF_A_RAW: rd_nxt[7:0] = a_if.raw_in;
      `GPM_OFF_B_RAW: rd_nxt[7:0] = b_if.raw_in;
      `GPM_OFF_C_RAW: rd_nxt[7:0] = c_if.raw_in;
      default: rd_nxt = 16'h0000; // Unmapped reads as zero
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_nxt : 16'h0000;
    end
  end

  // ----------------------------------------
  // Port bundles
  // ----------------------------------------
  assign a_if.gp_out = a_data_r;
  assign a_if.gp_dir = a_dir_r;
  assign a_if.per_en = a_peren_r;
  assign b_if.gp_out = b_data_r;
  assign b_if.gp_dir = b_dir_r;
  assign b_if.per_en = b_peren_r;
  assign c_if.gp_out = c_data_r;
  assign c_if.gp_dir = c_dir_r;
  assign c_if.per_en = c_peren_r;

  // ----------------------------------------
  // Port B peripheral mux
  // ----------------------------------------
  logic [7:0] b_per_out; // Peripheral drive value per pin
  logic [7:0] b_per_drv; // Peripheral drives the pin
  // Open-drain I2C lines drive only low; their value is held at zero
  always_comb begin
    b_per_out = 8'h00;
    b_per_drv = 8'h00;
    // Pin 0: SPI clock or I2C clock, see RULE2
    b_per_out[0] = pinsel_r[`GPM_B_PINSEL_BIT0] ? 1'b0 : spi_sclk_out;
    b_per_drv[0] = pinsel_r[`GPM_B_PINSEL_BIT0] ? i2c_scl_out_n : spi_sclk_oe;
    // Pin 1: slave select or I2C data, see RULE3
    b_per_out[1] = pinsel_r[`GPM_B_PINSEL_BIT1] ? 1'b0 : spi_ss_out;
    b_per_drv[1] = pinsel_r[`GPM_B_PINSEL_BIT1] ? i2c_sda_out_n : spi_ss_oe;
    // Pins 2 and 3: SPI data or timers 2 and 3, see RULE4
    b_per_out[2] = pinsel_r[`GPM_B_PINSEL_BIT2] ? timer_channel_2_out : spi_miso_out;
    b_per_drv[2] = pinsel_r[`GPM_B_PINSEL_BIT2] ? timer_channel_2_oe : spi_miso_oe;
    b_per_out[3] = pinsel_r[`GPM_B_PINSEL_BIT3] ? timer_channel_3_out : spi_mosi_out;
    b_per_drv[3] = pinsel_r[`GPM_B_PINSEL_BIT3] ? timer_channel_3_oe : spi_mosi_oe;
    // Pin 4: timer 0 or clock output, see RULE5
    b_per_out[4] = pinsel_r[`GPM_B_PINSEL_BIT4] ? internal_clock_output : timer_channel_0_out;
    b_per_drv[4] = pinsel_r[`GPM_B_PINSEL_BIT4] ? 1'b1 : timer_channel_0_oe;
    // Pin 5: timer 1 or fault input (input only), see RULE6
    b_per_out[5] = pinsel_r[`GPM_B_PINSEL_BIT5] ? 1'b0 : timer_channel_1_out;
    b_per_drv[5] = pinsel_r[`GPM_B_PINSEL_BIT5] ? 1'b0 : timer_channel_1_oe;
    // Pin 6: serial receive (input) or I2C data, see RULE7
    b_per_out[6] = 1'b0;
    b_per_drv[6] = pinsel_r[`GPM_B_PINSEL_BIT6] ? i2c_sda_out_n : 1'b0;
    // Pin 7: serial transmit or I2C clock, see RULE9
    b_per_out[7] = pinsel_r[`GPM_B_PINSEL_BIT7] ? 1'b0 : sci_txd_out;
    b_per_drv[7] = pinsel_r[`GPM_B_PINSEL_BIT7] ? i2c_scl_out_n : 1'b1;
  end

  // External clock taps pin 6 only when the PLL control enables it; see RULE8
  assign external_clock_input = pll_ext_clk_en & b_if.raw_in[6];
  assign pwm_fault_input_3 = b_if.per_en[5] & pinsel_r[`GPM_B_PINSEL_BIT5]
                             & b_if.raw_in[5]; // see RULE6
  assign pb_periph_in = b_if.raw_in & b_if.per_en;

  // ----------------------------------------
  // Pad outputs, enable low while driving
  // ----------------------------------------
  // Six A pins are bonded; A3/A6 logic still runs, see RULE1 see RULE10
  always_ff @(posedge mclk) begin
    if (rst) begin
      pa_out <= 8'h00;
      pa_oe_n <= 8'hff;
      pb_out <= 8'h00;
      pb_oe_n <= 8'hff;
      pc_out <= 8'h00;
      pc_oe_n <= 8'hff;
      pd_out <= 4'h0;
      pd_oe_n <= 4'hf;
    end else begin
      pa_out <= `GPM_A_PINS_MASK & ((a_if.per_en & pa_periph_out) | (~a_if.per_en & a_if.gp_out));
      pa_oe_n <= ~((a_if.per_en & pa_periph_oe) | (~a_if.per_en & a_if.gp_dir));
      pb_out <= (b_if.per_en & b_per_out) | (~b_if.per_en & b_if.gp_out); // see RULE2
      pb_oe_n <= ~((b_if.per_en & b_per_drv) | (~b_if.per_en & b_if.gp_dir));
      pc_out <= ~c_if.per_en & c_if.gp_out;
      pc_oe_n <= ~(~c_if.per_en & c_if.gp_dir); // see RULE11
      pd_out <= (d_peren_r & jtag_out) | (~d_peren_r & d_data_r);
      // Open-drain GPIO output drives only low
      pd_oe_n <= ~((d_peren_r & jtag_oe)
                   | (~d_peren_r & d_dir_r & (d_ppmode_r | ~d_data_r)));
    end
  end

  assign pc_analog_sel = c_if.per_en;
  assign pa_periph_in = a_if.raw_in & a_if.per_en;
  assign jtag_in = d_sync[3:0] & d_peren_r;
  assign pd_pull_en = d_pull_r;
  assign pd_open_drain = ~d_ppmode_r;
  assign pd_high_drive = d_drive_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_B_GPIO_AFTER_RESET: assert property (@(posedge mclk) // see RULE2
    $fell(rst) |-> b_peren_r == `GPM_RST_B_PEREN)
    else $error("port B not GPIO after reset");
  AST_A7_RESET_ROLE: assert property (@(posedge mclk) // see RULE11
    $fell(rst) |-> a_peren_r == `GPM_RST_A_PEREN)
    else $error("port A reset roles wrong");
  AST_D_RESET_VALS: assert property (@(posedge mclk) // see RULE12
    $fell(rst) |-> d_pull_r == `GPM_RST_D_ONES && d_peren_r == `GPM_RST_D_ONES
                   && d_ppmode_r == `GPM_RST_D_ONES)
    else $error("port D reset values wrong");
  AST_EXTCLK_GATE: assert property (@(posedge mclk) disable iff (rst) // see RULE8
    !pll_ext_clk_en |-> !external_clock_input)
    else $error("external clock passed while disabled");
  AST_B4_CLKOUT: assert property (@(posedge mclk) disable iff (rst) // see RULE5
    b_peren_r[4] && pinsel_r[`GPM_B_PINSEL_BIT4]
    |=> pb_out[4] == $past(internal_clock_output))
    else $error("clock output not routed");
  AST_B2_TIMER: assert property (@(posedge mclk) disable iff (rst) // see RULE4
    b_peren_r[2] && pinsel_r[`GPM_B_PINSEL_BIT2]
    |=> pb_out[2] == $past(timer_channel_2_out))
    else $error("timer 2 not routed");
  AST_B7_TXD: assert property (@(posedge mclk) disable iff (rst) // see RULE9
    b_peren_r[7] && !pinsel_r[`GPM_B_PINSEL_BIT7]
    |=> !pb_oe_n[7] && pb_out[7] == $past(sci_txd_out))
    else $error("serial transmit not routed");
  AST_B6_RX_INPUT: assert property (@(posedge mclk) disable iff (rst) // see RULE7
    b_peren_r[6] && !pinsel_r[`GPM_B_PINSEL_BIT6] |=> pb_oe_n[6])
    else $error("serial receive pin driven");
  AST_EDGE_STICKY: assert property (@(posedge mclk) disable iff (rst) // see RULE12
    d_edge_evt != 4'h0 |=> (d_iedge_r & $past(d_edge_evt)) == $past(d_edge_evt))
    else $error("edge event lost");
endmodule

// ==== gpio_ports_pin_mux_test.sv ====
// Self-checking testbench for the port and pin-mux block.
`timescale 1ns/100ps
`include "gpm_defs.svh"
module gpio_ports_pin_mux_test
  import gpm_pkg::*;
;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic mclk;
  logic rst;
  logic reg_wr;
  logic reg_rd;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata;
  gpm_word_t reg_rdata;
  logic [7:0] pa_in, pb_in, pc_in, pa_periph_out, pa_periph_oe;
  logic [3:0] pd_in, jtag_out, jtag_oe;
  gpm_port8_t pa_out, pa_oe_n, pb_out, pb_oe_n, pc_out, pc_oe_n, pc_analog_sel;
  gpm_port8_t pb_periph_in, pa_periph_in;
  gpm_port4_t pd_out, pd_oe_n, pd_pull_en, pd_open_drain, pd_high_drive;
  gpm_port4_t pd_irq_pending, jtag_in;
  logic external_clock_input, pwm_fault_input_3;
  logic [20:0] pbp; // Port B peripheral inputs packed; bit 20 is the PLL enable
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0; // Cycle counter for the hang guard
  // Port D reset image, offsets 0x0 to 0xb, raw level read with pins low
  logic [15:0] dexp [12] = '{16'h000f, 16'h0000, 16'h0000, 16'h000f, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000f, 16'h0000, 16'h0000};

  // ----------------------------------------
  // Clock, design and hang guard
  // ----------------------------------------
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  gpm_top dut_u (.*,
    .spi_sclk_out(pbp[0]), .spi_sclk_oe(pbp[1]), .i2c_scl_out_n(pbp[2]),
    .spi_ss_out(pbp[3]), .spi_ss_oe(pbp[4]), .i2c_sda_out_n(pbp[5]),
    .spi_miso_out(pbp[6]), .spi_miso_oe(pbp[7]), .spi_mosi_out(pbp[8]),
    .spi_mosi_oe(pbp[9]), .timer_channel_0_out(pbp[10]), .timer_channel_0_oe(pbp[11]),
    .timer_channel_1_out(pbp[12]), .timer_channel_1_oe(pbp[13]),
    .timer_channel_2_out(pbp[14]), .timer_channel_2_oe(pbp[15]),
    .timer_channel_3_out(pbp[16]), .timer_channel_3_oe(pbp[17]),
    .internal_clock_output(pbp[18]), .sci_txd_out(pbp[19]), .pll_ext_clk_en(pbp[20]));

  // Whole run is under two hundred cycles; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compare with case equality so an unknown never matches
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe beside address and data
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    // Leave on an edge so the caller's next stimulus lands on one
    @(posedge mclk);
  endtask

  // Covers two sync edges plus the edge detector, and the two-edge write-to-pin path
  task automatic pins();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata, pa_in, pb_in, pc_in, pd_in} = '0;
    {pa_periph_out, pa_periph_oe, jtag_out, jtag_oe, pbp} = '0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // Reset image of port D, pin-select and peripheral-enable registers
    for (int i = 0; i < 12; i++) begin
      rchk(5'(i), dexp[i]);
    end
    rchk(`GPM_OFF_PINSEL, 16'h0000);
    rchk(`GPM_OFF_A_PEREN, 16'h0080);
    rchk(`GPM_OFF_B_PEREN, 16'h0000);
    rchk(`GPM_OFF_C_PEREN, 16'h00ff);
    // Default pin roles: A7 and port D follow their peripherals, C analog
    pa_periph_oe <= 8'h80;
    pa_periph_out <= 8'h80;
    jtag_oe <= 4'ha;
    jtag_out <= 4'hf;
    pd_in <= 4'hf;
    pins();
    chk(pa_oe_n, 8'h7f);
    chk(pa_out & 8'h80, 8'h80);
    chk(pc_oe_n, 8'hff);
    chk(pc_analog_sel, 8'hff);
    chk(pc_out, 8'h00);
    chk(pb_oe_n, 8'hff);
    chk(pd_oe_n, 4'h5);
    chk(pd_out & 4'ha, 4'ha);
    chk(jtag_in, 4'hf);
    chk({pd_pull_en, pd_open_drain, pd_high_drive}, 12'hf00);
    $display("test reset defaults done");
    // Width trimming, unmapped and read-only places
    wr(`GPM_OFF_D_DRIVE, 16'hffff);
    rchk(`GPM_OFF_D_DRIVE, 16'h000f);
    chk(pd_high_drive, 4'hf);
    wr(5'h0c, 16'h1234);
    rchk(5'h0c, 16'h0000);
    wr(`GPM_OFF_D_IPEND, 16'hffff);
    rchk(`GPM_OFF_D_IPEND, 16'h0000);
    rchk(`GPM_OFF_D_RAW, 16'h000f);
    $display("test register access done");
    // Port A unbonded bits 3 and 6 still drive and read back
    wr(`GPM_OFF_A_DIR, 16'h0048);
    wr(`GPM_OFF_A_DATA, 16'h0048);
    pa_in <= 8'hc8;
    pins();
    chk(pa_oe_n, 8'h37);
    chk(pa_out, 8'hc8);
    rchk(`GPM_OFF_A_RAW, 16'h00c8);
    chk(pa_periph_in, 8'h80);
    $display("test port a done");
    // Port C upper half stays analog, lower half becomes driven GPIO
    wr(`GPM_OFF_C_PEREN, 16'h00f0);
    wr(`GPM_OFF_C_DIR, 16'h00ff);
    wr(`GPM_OFF_C_DATA, 16'h00ff);
    pins();
    chk(pc_oe_n, 8'hf0);
    chk(pc_out, 8'h0f);
    chk(pc_analog_sel, 8'hf0);
    $display("test port c done");
    // Port B first choice of every pin: B6 is an input, the rest drive
    wr(`GPM_OFF_B_PEREN, 16'h00ff);
    pbp <= 21'h0fffff;
    pins();
    chk(pb_oe_n, 8'h40);
    chk(pb_out & 8'hbf, 8'hbf);
    // Second choice: I2C lines pull low, B5 becomes the fault input
    wr(`GPM_OFF_PINSEL, 16'h00ff);
    pins();
    chk(pb_oe_n, 8'h20);
    chk(pb_out & 8'hdf, 8'h1c);
    // I2C released: those four pins must float
    @(posedge mclk);
    pbp[2] <= 1'b0;
    pbp[5] <= 1'b0;
    pb_in <= 8'h60;
    pins();
    chk(pb_oe_n, 8'he3);
    chk(pwm_fault_input_3, 1'b1);
    chk(pb_periph_in, 8'h60);
    chk(external_clock_input, 1'b0);
    // The clock input is gated by the PLL enable alone, not by the pin select
    @(posedge mclk);
    pbp[20] <= 1'b1;
    wr(`GPM_OFF_PINSEL, 16'h00df);
    pins();
    chk(external_clock_input, 1'b1);
    chk(pwm_fault_input_3, 1'b0);
    $display("test port b mux done");
    // Port B back to GPIO
    wr(`GPM_OFF_B_PEREN, 16'h0000);
    wr(`GPM_OFF_B_DIR, 16'h000f);
    wr(`GPM_OFF_B_DATA, 16'h00a5);
    pb_in <= 8'h3c;
    pins();
    chk(pb_oe_n, 8'hf0);
    chk(pb_out & 8'h0f, 8'h05);
    rchk(`GPM_OFF_B_RAW, 16'h003c);
    $display("test port b gpio done");
    // Port D as GPIO, push-pull then open drain, then events
    pd_in <= 4'h0;
    wr(`GPM_OFF_D_PEREN, 16'h0000);
    wr(`GPM_OFF_D_DIR, 16'h000f);
    wr(`GPM_OFF_D_DATA, 16'h0005);
    wr(`GPM_OFF_D_PULL, 16'h0000);
    pins();
    chk(pd_out, 4'h5);
    chk(pd_oe_n, 4'h0);
    chk(pd_pull_en, 4'h0);
    wr(`GPM_OFF_D_PPMODE, 16'h0000);
    wr(`GPM_OFF_D_IEN, 16'h0003);
    wr(`GPM_OFF_D_IASSERT, 16'h0001);
    pins();
    chk(pd_oe_n, 4'h5);
    chk(pd_open_drain, 4'hf);
    chk(pd_irq_pending, 4'h1);
    @(posedge mclk);
    pd_in <= 4'h2;
    pins();
    chk(pd_irq_pending, 4'h3);
    rchk(`GPM_OFF_D_IEDGE, 16'h0002);
    wr(`GPM_OFF_D_IEDGE, 16'h0002);
    pins();
    chk(pd_irq_pending, 4'h1);
    // Falling-edge polarity on bit 1
    wr(`GPM_OFF_D_IPOL, 16'h0002);
    pd_in <= 4'h0;
    pins();
    chk(pd_irq_pending, 4'h3);
    rchk(`GPM_OFF_D_IEDGE, 16'h0002);
    $display("test port d done");
    stop_test();
  end
endmodule
